// ===== host_side_model.sv
// Host processor model for the wake handshakes
`timescale 1ns/1ps
`default_nettype none
module host_side_model #(parameter int WAKE_DELAY = 4) (
   input wire logic mclk,
   input wire logic wake_req,
   input wire logic wake_high,
   input wire logic sleep_req,
   input wire logic spi_int,
   output logic device_wake_in,
   output logic host_sleeping
);
   // ----------------------------------------
   // Host behaviour
   // ----------------------------------------
   int cnt = 0;
   assign device_wake_in = wake_high ? wake_req : !wake_req;
   assign host_sleeping = sleep_req && cnt < WAKE_DELAY;
   always @(negedge mclk) begin
      if (!sleep_req) cnt <= 0;
      else if (spi_int && cnt < WAKE_DELAY) cnt <= cnt + 1;
   end
endmodule // host_side_model
`default_nettype wire

// ===== interval_timer.v
// Reloading down-counter that pulses on expiry
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wake_power_manager_defs.vh"

module interval_timer (
   input wire clk,
   input wire clr,
   input wire run,
   input wire tick,
   input wire [`TMR_W-1:0] period,
   output reg expire
);

   reg [`TMR_W-1:0] count;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always @(posedge clk) begin
      if (clr || !run) begin
         count <= period;
         expire <= 1'b0;
      end else if (tick) begin
         if (count <= `TMR_W'h0001) begin
            count <= period;
            expire <= 1'b1;
         end else begin
            count <= count - `TMR_W'h0001;
            expire <= 1'b0;
         end
      end else begin
         expire <= 1'b0;
      end
   end

endmodule // interval_timer
`default_nettype wire

// ===== power_manager_chk.sv
// Port checks for the power manager
`timescale 1ns/1ps
`default_nettype none
module power_manager_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_enable,
   input wire logic refclk_polarity_strap,
   input wire logic wake_on_uart,
   input wire logic host_attention,
   input wire logic core_rts_n,
   input wire logic spi_mode,
   input wire logic host_sleeping,
   input wire logic init_done,
   input wire logic periph_power_en,
   input wire logic nonessential_clk_en,
   input wire logic core_power_en,
   input wire logic uart_rts_n,
   input wire logic spi_int,
   input wire logic clk_req,
   input wire logic regulator_en,
   input wire logic init_needed,
   input wire logic sleeping,
   input wire logic event_wake
);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n || !reg_enable);
   AST_SLEEP_GATE: assert property (sleeping |-> core_power_en && !periph_power_en && !nonessential_clk_en)
      else $error("sleep gating wrong");
   AST_CLKREQ_POL: assert property (sleeping |-> clk_req == !refclk_polarity_strap)
      else $error("clock request level wrong in sleep");
   AST_RTS_WAKE: assert property (wake_on_uart && host_attention |=> !uart_rts_n)
      else $error("rts not asserted for host wake");
   AST_RTS_FLOW: assert property (!wake_on_uart |=> uart_rts_n == $past(core_rts_n))
      else $error("rts not following flow control");
   AST_SPI_INT: assert property (spi_mode && host_sleeping && host_attention |=> spi_int)
      else $error("spi interrupt missing");
   AST_REG_ON: assert property (rst_n |=> regulator_en)
      else $error("regulator not enabled");
   AST_INIT_HOLD: assert property (init_needed && !init_done |=> init_needed)
      else $error("init flag dropped early");
   AST_EVENT_PULSE: assert property (event_wake |=> !event_wake)
      else $error("event wake longer than one cycle");
endmodule // power_manager_chk
bind sleep_wake_power_manager power_manager_chk power_manager_chk_i (.*);
`default_nettype wire

// ===== sleep_wake_power_manager.v
// Sleep, wake and power-gating controller
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wake_power_manager_defs.vh"

module sleep_wake_power_manager (
   input wire mclk,
   input wire rst_n,
   input wire reg_enable,
   input wire refclk_polarity_strap,
   input wire low_power_osc,
   input wire device_wake_in,
   input wire uart_cts_n,
   input wire serial_select_low,
   input wire wake_on_uart,
   input wire spi_mode,
   input wire wake_pol_wr,
   input wire wake_pol_high,
   input wire host_pol_wr,
   input wire host_pol_high,
   input wire sleep_enable,
   input wire timed_wake_en,
   input wire [`TMR_W-1:0] timed_wake_ticks,
   input wire session_en,
   input wire [`TMR_W-1:0] session_ticks,
   input wire conn_lp_en,
   input wire [`TMR_W-1:0] conn_ticks,
   input wire event_done,
   input wire spi_idle_en,
   input wire [`TMR_W-1:0] spi_idle_cycles,
   input wire host_attention,
   input wire host_sleeping,
   input wire core_rts_n,
   input wire tx_active,
   input wire rx_active,
   input wire shutdown_req,
   input wire init_done,
   output reg tx_pd,
   output reg rx_pd,
   output reg pll_pd,
   output reg pa_pd,
   output reg periph_power_en,
   output reg nonessential_clk_en,
   output reg core_power_en,
   output reg digital_clk_en,
   output reg analog_clk_en,
   output reg io_oe_n,
   output reg host_wake_out,
   output reg uart_rts_n,
   output reg spi_int,
   output reg clk_req,
   output reg regulator_en,
   output reg init_needed,
   output reg sleeping,
   output reg event_wake
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [`ST_W-1:0] ST_OFF = 3'h0;
   localparam [`ST_W-1:0] ST_ACTIVE = 3'h1;
   localparam [`ST_W-1:0] ST_SLEEP = 3'h2;
   localparam [`ST_W-1:0] ST_EVENT = 3'h3;
   localparam [`ST_W-1:0] ST_SHUTDOWN = 3'h4;

   reg [`ST_W-1:0] state;
   reg [`ST_W-1:0] next_state;
   reg [2:0] wake_sync;
   reg [2:0] cts_sync;
   reg [2:0] sel_sync;
   reg [2:0] osc_sync;
   reg wake_pol;
   reg host_pol;
   reg strap_seen;
   reg strap_pol;
   reg idle_done;
   wire kill;
   wire osc_tick;
   wire osc_run;
   wire wake_level;
   wire wake_act;
   wire sel_act;
   wire sleep_ok;
   wire awake;
   wire timed_exp;
   wire session_exp;
   wire conn_exp;
   wire idle_exp;
   wire sched_exp;

   // ----------------------------------------
   // Power cycle reset
   // ----------------------------------------
   // R20: regulator drop resets
   assign kill = !rst_n || !reg_enable;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // R21: three-stage sync
   always @(posedge mclk) begin
      if (kill) begin
         wake_sync <= `WAKE_SYNC_RST;
         cts_sync <= `WAKE_SYNC_RST;
         sel_sync <= `WAKE_SYNC_RST;
         osc_sync <= `OSC_SYNC_RST;
      end else begin
         wake_sync <= {wake_sync[1:0], device_wake_in};
         cts_sync <= {cts_sync[1:0], uart_cts_n};
         sel_sync <= {sel_sync[1:0], serial_select_low};
         osc_sync <= {osc_sync[1:0], low_power_osc};
      end
   end

   // R03: slow oscillator tick
   assign osc_tick = osc_sync[1] && !osc_sync[2];
   // R19: slow oscillator timers frozen in shutdown
   assign osc_run = osc_tick && state != ST_SHUTDOWN;

   // ----------------------------------------
   // Polarity settings and strap
   // ----------------------------------------
   always @(posedge mclk) begin
      if (kill) begin
         wake_pol <= `WAKE_POL_RST;
         host_pol <= `HOST_POL_RST;
         strap_seen <= 1'b0;
         strap_pol <= 1'b0;
      end else begin
         // R13: wake polarity select
         if (wake_pol_wr) begin
            wake_pol <= wake_pol_high;
         end
         // R14: host wake polarity
         if (host_pol_wr) begin
            host_pol <= host_pol_high;
         end
         // R15: strap caught after release
         if (!strap_seen) begin
            strap_seen <= 1'b1;
            strap_pol <= refclk_polarity_strap;
         end
      end
   end

   // ----------------------------------------
   // Wake decode
   // ----------------------------------------
   // R08: pin or CTS wake source
   assign wake_level = wake_on_uart ? !cts_sync[2] : wake_sync[2];
   // R13: apply wake polarity
   assign wake_act = wake_pol ? wake_level : !wake_level;
   // R11: select low is wake
   assign sel_act = spi_mode && !sel_sync[2];

   // ----------------------------------------
   // Timers
   // ----------------------------------------
   // R03: timed wake in sleep
   interval_timer u_timed (
      .clk(mclk),
      .clr(kill),
      .run(timed_wake_en && state == ST_SLEEP),
      .tick(osc_run),
      .period(timed_wake_ticks),
      .expire(timed_exp)
   );

   // R04: scan or sniff schedule
   interval_timer u_session (
      .clk(mclk),
      .clr(kill),
      .run(session_en),
      .tick(osc_run),
      .period(session_ticks),
      .expire(session_exp)
   );

   // R18: connection low-power interval
   interval_timer u_conn (
      .clk(mclk),
      .clr(kill),
      .run(conn_lp_en),
      .tick(osc_run),
      .period(conn_ticks),
      .expire(conn_exp)
   );

   // R09: select idle counter
   interval_timer u_idle (
      .clk(mclk),
      .clr(kill || sel_act),
      .run(spi_mode && spi_idle_en && !idle_done),
      .tick(1'b1),
      .period(spi_idle_cycles),
      .expire(idle_exp)
   );

   assign sched_exp = session_exp || conn_exp;

   // R09: idle expiry latch
   always @(posedge mclk) begin
      if (kill || sel_act || !spi_idle_en) begin
         idle_done <= 1'b0;
      end else if (idle_exp) begin
         idle_done <= 1'b1;
      end
   end

   // ----------------------------------------
   // Sleep criteria
   // ----------------------------------------
   // R07: wake input blocks sleep
   // R10: host-set idle sleep mode
   assign sleep_ok = !wake_act && !sel_act && !host_attention &&
                     ((spi_mode && spi_idle_en) ? idle_done : sleep_enable);

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            next_state = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            // R02: enter retention sleep
            if (sleep_ok) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // R05: host wake any time
            if (wake_act || sel_act) begin
               next_state = ST_ACTIVE;
            end else if (timed_exp) begin
               next_state = ST_ACTIVE;
            // R04: wake for event
            end else if (sched_exp) begin
               next_state = ST_EVENT;
            end
         end
         ST_EVENT: begin
            // R06: host wake keeps awake
            if (wake_act || sel_act) begin
               next_state = ST_ACTIVE;
            // R04: resleep after event
            end else if (event_done) begin
               next_state = sleep_ok ? ST_SLEEP : ST_ACTIVE;
            end
         end
         ST_SHUTDOWN: begin
            if (!shutdown_req) begin
               next_state = ST_ACTIVE;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
      // R19: shutdown from any state except ST_OFF
      if (shutdown_req && state != ST_OFF) begin
         next_state = ST_SHUTDOWN;
      end
   end

   // R20: power cycle restarts
   always @(posedge mclk) begin
      if (kill) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   assign awake = next_state == ST_ACTIVE || next_state == ST_EVENT;

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always @(posedge mclk) begin
      if (kill) begin
         tx_pd <= 1'b1;
         rx_pd <= 1'b1;
         pll_pd <= 1'b1;
         pa_pd <= 1'b1;
         periph_power_en <= 1'b0;
         nonessential_clk_en <= 1'b0;
         core_power_en <= 1'b0;
         digital_clk_en <= 1'b0;
         analog_clk_en <= 1'b0;
         io_oe_n <= 1'b1;
         host_wake_out <= !`HOST_POL_RST;
         uart_rts_n <= 1'b1;
         spi_int <= 1'b0;
         clk_req <= 1'b0;
         regulator_en <= 1'b0;
         init_needed <= `INIT_NEEDED_RST;
         sleeping <= 1'b0;
         event_wake <= 1'b0;
      end else begin
         // R01: per-path power-down
         // R17: RF on only in packet
         tx_pd <= !(awake && tx_active);
         rx_pd <= !(awake && rx_active);
         pll_pd <= !(awake && (tx_active || rx_active));
         pa_pd <= !(awake && tx_active);
         // R02: gate nonessential, keep core
         periph_power_en <= awake;
         nonessential_clk_en <= awake;
         core_power_en <= next_state != ST_SHUTDOWN;
         // R19: stop clocks, tristate
         digital_clk_en <= next_state != ST_SHUTDOWN;
         analog_clk_en <= awake;
         io_oe_n <= next_state == ST_SHUTDOWN;
         // R14: host wake on attention
         host_wake_out <= host_pol ? host_attention : !host_attention;
         // R08: RTS doubles as host wake
         uart_rts_n <= (wake_on_uart && host_attention) ? 1'b0 : core_rts_n;
         // R12: interrupt wakes host
         spi_int <= spi_mode && host_sleeping && host_attention;
         // R15: clock request polarity
         clk_req <= strap_seen ? (strap_pol ? awake : !awake)
                               : (refclk_polarity_strap ? awake : !awake);
         // R16: regulators follow enable
         regulator_en <= 1'b1;
         // R20: fresh init required
         if (init_done) begin
            init_needed <= 1'b0;
         end
         // R02: sleep status flag
         sleeping <= next_state == ST_SLEEP;
         // R06: events flagged in any state except shutdown
         event_wake <= sched_exp && state != ST_SHUTDOWN;
      end
   end

endmodule // sleep_wake_power_manager
`default_nettype wire

// ===== sleep_wake_power_manager_defs.vh
// Constants for the sleep and wake power manager
//
// Behaviour
// R01: Separate TX, RX, PLL, PA power-down outputs
// R02: Sleep gates nonessential power and clocks, keeps core
// R03: Sleep timer on slow oscillator, timed or host wake
// R04: Scan/sniff timers wake per event, resleep after
// R05: Host wake accepted any time during sleep
// R06: Host wake during session keeps device awake
// R07: Wake input asserted blocks sleep; deasserted permits
// R08: Wake via dedicated pins or UART CTS/RTS
// R09: SPI idle select for programmed time sleeps
// R10: Host configures SPI idle sleep and duration
// R11: SPI select assertion wakes the device
// R12: SPI interrupt wakes sleeping host with data
// R13: Wake input polarity selectable, resets active low
// R14: Host wake output asserted when attention needed
// R15: Clock request follows need, strap sets polarity
// R16: Regulator enable high enables both regulators
// R17: RF powered only while packet needs it
// R18: Sniff/hold/park wake after programmed interval
// R19: Shutdown tristates outputs and stops all clocks
// R20: Regulator re-enable is a full fresh power-up
// R21: Wake inputs synchronised before use
`ifndef SLEEP_WAKE_POWER_MANAGER_DEFS_VH
`define SLEEP_WAKE_POWER_MANAGER_DEFS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TMR_W 16
`define ST_W 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WAKE_POL_RST 1'h0
`define HOST_POL_RST 1'h1
`define TMR_CNT_RST 16'h0000
`define INIT_NEEDED_RST 1'h1

// ----------------------------------------
// Synchroniser idle levels
// ----------------------------------------
`define WAKE_SYNC_RST 3'h7
`define OSC_SYNC_RST 3'h7

`endif

// ===== sleep_wake_power_manager_tb.sv
// Self-checking bench for the sleep and wake power manager
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wake_power_manager_defs.vh"
module sleep_wake_power_manager_tb;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic mclk = 1'h0, rst_n = 1'h0, reg_enable = 1'h1, refclk_polarity_strap = 1'h1, low_power_osc = 1'h0;
   logic uart_cts_n, serial_select_low, core_rts_n, wake_on_uart, spi_mode, wake_pol_wr, wake_pol_high;
   logic host_pol_wr, host_pol_high, sleep_enable, timed_wake_en, session_en, conn_lp_en, event_done;
   logic spi_idle_en, host_attention, tx_active, rx_active, shutdown_req, init_done, wake_req, wake_high, sleep_req;
   logic [`TMR_W-1:0] timed_wake_ticks = 16'h0003, session_ticks = 16'h0002, conn_ticks = 16'h0003;
   logic [`TMR_W-1:0] spi_idle_cycles = 16'h0010;
   wire device_wake_in, host_sleeping, tx_pd, rx_pd, pll_pd, pa_pd, periph_power_en, nonessential_clk_en;
   wire core_power_en, digital_clk_en, analog_clk_en, io_oe_n, host_wake_out, uart_rts_n, spi_int, clk_req;
   wire regulator_en, init_needed, sleeping, event_wake;
   int mismatches = 0, compares = 0;
   sleep_wake_power_manager sleep_wake_power_manager_i (.*);
   host_side_model host_side_model_i (.mclk(mclk), .wake_req(wake_req), .wake_high(wake_high),
      .sleep_req(sleep_req), .spi_int(spi_int), .device_wake_in(device_wake_in), .host_sleeping(host_sleeping));
   always #2 mclk = ~mclk;
   always begin
      repeat (5) @(negedge mclk);
      low_power_osc = ~low_power_osc;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task chk(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %b expected %b", $time, got, exp);
      end
   endtask
   task results;
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task wt(input logic ev, input logic v);
      for (int n = 0; n < 400 && (ev ? event_wake : sleeping) !== v; n++) @(negedge mclk);
      chk(ev ? event_wake : sleeping, v);
      if ((ev ? event_wake : sleeping) !== v) results;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      {uart_cts_n, serial_select_low, core_rts_n} = 3'h7;
      {wake_on_uart, spi_mode, wake_pol_wr, wake_pol_high, host_pol_wr, host_pol_high, sleep_enable} = 7'h00;
      {timed_wake_en, session_en, conn_lp_en, event_done, spi_idle_en, host_attention, tx_active} = 7'h00;
      {rx_active, shutdown_req, init_done, wake_req, wake_high, sleep_req} = 6'h00;
      cyc(8);
      rst_n = 1'h1;
      cyc(2);
      chk(io_oe_n, 1'h0);
      chk(regulator_en, 1'h1);
      chk(clk_req, 1'h1);
      chk(init_needed, 1'h1);
      init_done = 1'h1;
      cyc(1);
      init_done = 1'h0;
      tx_active = 1'h1;
      cyc(2);
      chk(init_needed, 1'h0);
      chk(tx_pd, 1'h0);
      chk(rx_pd, 1'h1);
      chk(pa_pd, 1'h0);
      chk(pll_pd, 1'h0);
      {tx_active, rx_active} = 2'h1;
      cyc(2);
      chk(tx_pd, 1'h1);
      chk(rx_pd, 1'h0);
      chk(pa_pd, 1'h1);
      chk(pll_pd, 1'h0);
      rx_active = 1'h0;
      wake_req = 1'h1;
      cyc(4);
      sleep_enable = 1'h1;
      cyc(20);
      chk(sleeping, 1'h0);
      wake_req = 1'h0;
      wt(1'h0, 1'h1);
      chk(periph_power_en, 1'h0);
      chk(core_power_en, 1'h1);
      chk(nonessential_clk_en, 1'h0);
      chk(pll_pd, 1'h1);
      wake_req = 1'h1;
      wt(1'h0, 1'h0);
      wake_pol_high = 1'h1;
      wake_pol_wr = 1'h1;
      wake_high = 1'h1;
      cyc(1);
      wake_pol_wr = 1'h0;
      cyc(20);
      chk(sleeping, 1'h0);
      wake_req = 1'h0;
      wt(1'h0, 1'h1);
      timed_wake_en = 1'h1;
      wt(1'h0, 1'h0);
      timed_wake_en = 1'h0;
      wt(1'h0, 1'h1);
      for (int k = 0; k < 2; k++) begin
         {session_en, conn_lp_en} = k ? 2'h1 : 2'h2;
         wt(1'h1, 1'h1);
         cyc(1);
         chk(sleeping, 1'h0);
         event_done = 1'h1;
         cyc(1);
         event_done = 1'h0;
         wt(1'h0, 1'h1);
         {session_en, conn_lp_en} = 2'h0;
      end
      session_en = 1'h1;
      wake_req = 1'h1;
      wt(1'h0, 1'h0);
      cyc(30);
      event_done = 1'h1;
      cyc(1);
      event_done = 1'h0;
      cyc(30);
      chk(sleeping, 1'h0);
      {session_en, wake_req, wake_on_uart} = 3'h1;
      wt(1'h0, 1'h1);
      uart_cts_n = 1'h0;
      wt(1'h0, 1'h0);
      host_attention = 1'h1;
      cyc(2);
      chk(uart_rts_n, 1'h0);
      chk(host_wake_out, 1'h1);
      host_pol_wr = 1'h1;
      cyc(1);
      host_pol_wr = 1'h0;
      cyc(2);
      chk(host_wake_out, 1'h0);
      {host_attention, sleep_enable, wake_on_uart, core_rts_n} = 4'h0;
      cyc(2);
      chk(host_wake_out, 1'h1);
      chk(uart_rts_n, 1'h0);
      {uart_cts_n, core_rts_n} = 2'h3;
      {spi_mode, spi_idle_en, serial_select_low} = 3'h6;
      cyc(6);
      serial_select_low = 1'h1;
      cyc(10);
      chk(sleeping, 1'h0);
      wt(1'h0, 1'h1);
      serial_select_low = 1'h0;
      wt(1'h0, 1'h0);
      {sleep_req, host_attention} = 2'h3;
      cyc(3);
      chk(spi_int, 1'h1);
      cyc(8);
      chk(spi_int, 1'h0);
      {sleep_req, host_attention, shutdown_req} = 3'h1;
      cyc(3);
      chk(io_oe_n, 1'h1);
      chk(digital_clk_en, 1'h0);
      chk(analog_clk_en, 1'h0);
      shutdown_req = 1'h0;
      cyc(3);
      chk(io_oe_n, 1'h0);
      {refclk_polarity_strap, reg_enable} = 2'h0;
      cyc(2);
      chk(regulator_en, 1'h0);
      chk(pa_pd, 1'h1);
      reg_enable = 1'h1;
      cyc(3);
      chk(init_needed, 1'h1);
      chk(clk_req, 1'h0);
      results;
   end
endmodule // sleep_wake_power_manager_tb
`default_nettype wire
